// File: hw/dbc_defines.svh
// register offsets, field positions and reset values of the data breakpoint channel
`ifndef DBC_DEFINES_SVH
`define DBC_DEFINES_SVH

// byte offsets within the debug register segment
`define DBC_OFF_ADDR     16'h2100
`define DBC_OFF_MASK     16'h2108
`define DBC_OFF_CTRL     16'h2118
`define DBC_OFF_VALUE    16'h2120
`define DBC_OFF_CPLX     16'h2128
`define DBC_OFF_PASS     16'h2130
`define DBC_OFF_STATUS   16'h2000
`define DBC_OFF_LOADV    16'h2FF0

// control register fields
`define DBC_C_BE         0
`define DBC_C_IVM        1
`define DBC_C_TE         2
`define DBC_C_BLM_LO     4
`define DBC_C_HWART      8
`define DBC_C_EXCL       9
`define DBC_C_RANGE_CAP  10
`define DBC_C_LOAD_SUPPRESS       12
`define DBC_C_STORE_SUPPRESS       13
`define DBC_C_BAI_LO     14

// complex control fields
`define DBC_X_CBE        9
`define DBC_X_PR_LO      10
`define DBC_X_TUP        15
`define DBC_X_TIB_LO     16

`define DBC_ZERO32       32'h0000_0000
`define DBC_ZERO16       16'h0000
`define DBC_ONE16        16'h0001
`define DBC_RESP_OK      1'b0
`define DBC_RESP_ERR     1'b1

`endif

// File: hw/dbc_pkg.sv
// types shared by the data breakpoint channel
package dbc_pkg;
  typedef logic [31:0] dbc_word_t;
  typedef logic [3:0]  dbc_lanes_t;
endpackage

// File: hw/dbc_channel.sv
// data breakpoint channel with apb register slave
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
`include "dbc_defines.svh"

// Behaviour
// - set byte-ignore bit disregards accesses to that data-bus byte
// - store-suppress set: stores never satisfy the condition
// - load-suppress set: loads never satisfy the condition
// - read-only range capability bit reads as one
// - range polarity zero matches inside range, one outside; resets zero
// - match method zero uses equality-mask, one uses range; resets zero
// - byte-lane mask bit one excludes that lane from value compare
// - trigger enable makes channel a triggerpoint; resets zero
// - value invert fires when data differs from compare value
// - break enable makes channel a breakpoint; resets zero
// - 32-bit read-write compare value register
// - read-only paired instruction channel number, preset per configuration
// - tuple enable requires paired instruction match on same instruction
// - upper priming selector bits read zero
// - two-bit priming selector, zero means bypass; resets zero
// - complex enable offers channel as priming or qualifying source
// - data qualifier select and qualify bit read zero, ignore writes
// - 16-bit pass counter decrements per match, suppresses actions while nonzero
// - counter stays at zero; later matches give actions
// - actions imprecise while last counter write was nonzero
// - upper half of pass counter register reads zero
// - precise value break on load captures load data read-only
// - address mask bit one excludes address bit; zeros exact, ones any
// - channel match sets its break status bit
module dbc_channel
  import dbc_pkg::*;
#(
  parameter logic [3:0] PAIRED_INSTR = 4'h0,
  parameter int         CHAN_IDX     = 0
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ls_valid,
  input  wire logic        ls_store,
  input  wire logic [31:0] ls_addr,
  input  wire logic [3:0]  ls_byte_en,
  input  wire logic [31:0] ls_data,
  input  wire logic        instr_pair_match,
  input  wire logic        primed,
  output logic             break_req,
  output logic             trigger_req,
  output logic             break_imprecise,
  output logic             complex_match,
  output logic             complex_enable
);

  // ****************************************************************
  // registers
  // ****************************************************************
  dbc_word_t  addr_reg,  addr_next;
  dbc_word_t  mask_reg,  mask_next;
  dbc_word_t  value_reg, value_next;
  dbc_word_t  loadv_reg, loadv_next;
  dbc_lanes_t bai_reg,   bai_next;
  dbc_lanes_t blm_reg,   blm_next;
  logic store_suppress_reg, store_suppress_next, load_suppress_reg, load_suppress_next;
  logic excl_reg, excl_next, hwart_reg, hwart_next;
  logic te_reg, te_next, ivm_reg, ivm_next, be_reg, be_next;
  logic tup_reg, tup_next, cbe_reg, cbe_next;
  logic [1:0]  prsel_reg, prsel_next;
  logic [15:0] pass_reg,  pass_next;
  logic        impr_reg,  impr_next;
  logic        bs_reg,    bs_next;
  logic        brk_reg,   brk_next;
  logic        trg_reg,   trg_next;
  logic        cm_reg,    cm_next;
  logic        impo_reg,  impo_next;
  dbc_word_t   rdata_reg, rdata_next;
  logic        err_reg,   err_next;

  // ****************************************************************
  // match logic
  // ****************************************************************
  logic wr_en, rd_en, mapped;
  logic addr_eq, addr_rng, addr_ok, val_eq, val_ok, lanes_ok, dir_ok, cond;
  logic fire;
  dbc_word_t lane_bits;

  // expand a four-lane byte mask to a bit mask
  function automatic dbc_word_t lane_expand(input dbc_lanes_t l);
    lane_expand = {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
  endfunction

  // apb is zero-wait; every access completes in its access phase
  assign pready = 1'b1;
  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && !penable && !pwrite;

  always_comb begin
    lane_bits = lane_expand(blm_reg);
    addr_eq   = ((ls_addr ^ addr_reg) & ~mask_reg) == `DBC_ZERO32;
    // range: mask register holds the upper bound, address the lower
    addr_rng  = (ls_addr >= addr_reg) && (ls_addr <= mask_reg);
    addr_ok   = hwart_reg ? (addr_rng ^ excl_reg) : addr_eq;
    val_eq    = ((ls_data ^ value_reg) & ~lane_bits) == `DBC_ZERO32;
    val_ok    = val_eq ^ ivm_reg;
    lanes_ok  = (ls_byte_en & ~bai_reg) != 4'h0;
    dir_ok    = ls_store ? !store_suppress_reg : !load_suppress_reg;
    cond      = ls_valid && lanes_ok && dir_ok && addr_ok && val_ok
                && (!tup_reg || instr_pair_match)
                && (prsel_reg == 2'b00 || primed);
    fire      = cond && (pass_reg == `DBC_ZERO16);
  end

  // ****************************************************************
  // next-state for registers, counter and outputs
  // ****************************************************************
  always_comb begin
    addr_next  = addr_reg;
    mask_next  = mask_reg;
    value_next = value_reg;
    bai_next   = bai_reg;
    blm_next   = blm_reg;
    store_suppress_next  = store_suppress_reg;
    load_suppress_next  = load_suppress_reg;
    excl_next  = excl_reg;
    hwart_next = hwart_reg;
    te_next    = te_reg;
    ivm_next   = ivm_reg;
    be_next    = be_reg;
    tup_next   = tup_reg;
    cbe_next   = cbe_reg;
    prsel_next = prsel_reg;
    impr_next  = impr_reg;
    loadv_next = loadv_reg;
    // counter decrement on each match while nonzero
    pass_next  = (cond && pass_reg != `DBC_ZERO16) ? pass_reg - `DBC_ONE16 : pass_reg;
    brk_next   = fire && be_reg;
    trg_next   = fire && te_reg;
    impo_next  = fire && impr_reg && (be_reg || te_reg);
    cm_next    = cond && cbe_reg;
    // status set wins over a software clear in the same cycle
    bs_next    = bs_reg;
    if (wr_en && paddr == `DBC_OFF_STATUS && !pwdata[CHAN_IDX]) begin
      bs_next = 1'b0;
    end
    if (cond) begin
      bs_next = 1'b1;
    end
    // precise value break on a load captures its data
    if (fire && be_reg && !ls_store && !impr_reg) begin
      loadv_next = ls_data;
    end
    if (wr_en) begin
      unique case (paddr)
        `DBC_OFF_ADDR:  addr_next  = pwdata;
        `DBC_OFF_MASK:  mask_next  = pwdata;
        `DBC_OFF_VALUE: value_next = pwdata;
        `DBC_OFF_CTRL: begin
          bai_next   = pwdata[`DBC_C_BAI_LO +: 4];
          store_suppress_next  = pwdata[`DBC_C_STORE_SUPPRESS];
          load_suppress_next  = pwdata[`DBC_C_LOAD_SUPPRESS];
          excl_next  = pwdata[`DBC_C_EXCL];
          hwart_next = pwdata[`DBC_C_HWART];
          blm_next   = pwdata[`DBC_C_BLM_LO +: 4];
          te_next    = pwdata[`DBC_C_TE];
          ivm_next   = pwdata[`DBC_C_IVM];
          be_next    = pwdata[`DBC_C_BE];
        end
        `DBC_OFF_CPLX: begin
          // qualifier fields are not stored at all
          tup_next   = pwdata[`DBC_X_TUP];
          prsel_next = pwdata[`DBC_X_PR_LO +: 2];
          cbe_next   = pwdata[`DBC_X_CBE];
        end
        `DBC_OFF_PASS: begin
          pass_next  = pwdata[15:0];
          impr_next  = pwdata[15:0] != `DBC_ZERO16;
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // read mux, captured in setup so prdata comes from a flip-flop
  // ****************************************************************
  always_comb begin
    mapped     = 1'b1;
    rdata_next = rdata_reg;
    unique case (paddr)
      `DBC_OFF_ADDR:   rdata_next = addr_reg;
      `DBC_OFF_MASK:   rdata_next = mask_reg;
      `DBC_OFF_VALUE:  rdata_next = value_reg;
      `DBC_OFF_CTRL:   rdata_next = {14'h0000, bai_reg, store_suppress_reg, load_suppress_reg, 1'b0,
                                     1'b1, excl_reg, hwart_reg, blm_reg, 1'b0,
                                     te_reg, ivm_reg, be_reg};
      `DBC_OFF_CPLX:   rdata_next = {12'h000, PAIRED_INSTR, tup_reg, 1'b0, 2'b00,
                                     prsel_reg, cbe_reg, 9'h000};
      `DBC_OFF_PASS:   rdata_next = {`DBC_ZERO16, pass_reg};
      `DBC_OFF_STATUS: rdata_next = `DBC_ZERO32 | (32'(bs_reg) << CHAN_IDX);
      `DBC_OFF_LOADV:  rdata_next = loadv_reg;
      default: begin
        mapped     = 1'b0;
        rdata_next = `DBC_ZERO32;
      end
    endcase
    if (!rd_en) begin
      rdata_next = rdata_reg;
    end
    err_next = (psel && !penable) ? !mapped : err_reg;
  end

  // ****************************************************************
  // flip-flops; undefined-reset fields are cleared for determinism
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg  <= `DBC_ZERO32;
      mask_reg  <= `DBC_ZERO32;
      value_reg <= `DBC_ZERO32;
      loadv_reg <= `DBC_ZERO32;
      bai_reg   <= 4'h0;
      blm_reg   <= 4'h0;
      store_suppress_reg  <= 1'b0;
      load_suppress_reg  <= 1'b0;
      excl_reg  <= 1'b0;
      hwart_reg <= 1'b0;
      te_reg    <= 1'b0;
      ivm_reg   <= 1'b0;
      be_reg    <= 1'b0;
      tup_reg   <= 1'b0;
      cbe_reg   <= 1'b0;
      prsel_reg <= 2'b00;
      pass_reg  <= `DBC_ZERO16;
      impr_reg  <= 1'b0;
      bs_reg    <= 1'b0;
      brk_reg   <= 1'b0;
      trg_reg   <= 1'b0;
      cm_reg    <= 1'b0;
      impo_reg  <= 1'b0;
      rdata_reg <= `DBC_ZERO32;
      err_reg   <= `DBC_RESP_OK;
    end else begin
      addr_reg  <= addr_next;
      mask_reg  <= mask_next;
      value_reg <= value_next;
      loadv_reg <= loadv_next;
      bai_reg   <= bai_next;
      blm_reg   <= blm_next;
      store_suppress_reg  <= store_suppress_next;
      load_suppress_reg  <= load_suppress_next;
      excl_reg  <= excl_next;
      hwart_reg <= hwart_next;
      te_reg    <= te_next;
      ivm_reg   <= ivm_next;
      be_reg    <= be_next;
      tup_reg   <= tup_next;
      cbe_reg   <= cbe_next;
      prsel_reg <= prsel_next;
      pass_reg  <= pass_next;
      impr_reg  <= impr_next;
      bs_reg    <= bs_next;
      brk_reg   <= brk_next;
      trg_reg   <= trg_next;
      cm_reg    <= cm_next;
      impo_reg  <= impo_next;
      rdata_reg <= rdata_next;
      err_reg   <= err_next;
    end
  end

  assign prdata          = rdata_reg;
  assign pslverr         = psel && penable && err_reg;
  assign break_req       = brk_reg;
  assign trigger_req     = trg_reg;
  assign break_imprecise = impo_reg;
  assign complex_match   = cm_reg;
  assign complex_enable  = cbe_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_store_never_breaks: assert property (@(posedge pclk) disable iff (!presetn)
    (ls_valid && ls_store && store_suppress_reg) |=> !break_req && !trigger_req)
    else $error("store matched while store suppress set");
  a_load_never_breaks: assert property (@(posedge pclk) disable iff (!presetn)
    (ls_valid && !ls_store && load_suppress_reg) |=> !break_req && !trigger_req)
    else $error("load matched while load suppress set");
  a_break_needs_enable: assert property (@(posedge pclk) disable iff (!presetn)
    break_req |-> $past(be_reg) && $past(pass_reg) == 16'h0000)
    else $error("break without enable or with counter nonzero");
  a_trig_needs_enable: assert property (@(posedge pclk) disable iff (!presetn)
    trigger_req |-> $past(te_reg))
    else $error("trigger without trigger enable");
  a_pass_decrements: assert property (@(posedge pclk) disable iff (!presetn)
    (cond && pass_reg != 16'h0000 && !wr_en) |=> pass_reg == $past(pass_reg) - 16'h0001)
    else $error("pass counter did not decrement");
  a_pass_holds_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (pass_reg == 16'h0000 && !wr_en) |=> pass_reg == 16'h0000)
    else $error("pass counter left zero");
  a_status_sets: assert property (@(posedge pclk) disable iff (!presetn)
    cond |=> bs_reg)
    else $error("status bit not set on match");
  a_imprecise_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `DBC_OFF_PASS) |=> impr_reg == ($past(pwdata[15:0]) != 16'h0000))
    else $error("imprecise flag wrong after counter write");
  a_tuple_qualifies: assert property (@(posedge pclk) disable iff (!presetn)
    (tup_reg && !instr_pair_match) |=> !break_req && !trigger_req)
    else $error("tuple fired without paired match");
  a_capture_load: assert property (@(posedge pclk) disable iff (!presetn)
    (fire && be_reg && !ls_store && !impr_reg) |=> loadv_reg == $past(ls_data))
    else $error("load value not captured");

  // ****************************************************************
  // assertions on qualifiers and register reads
  // ****************************************************************
  a_lanes_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (ls_valid && (ls_byte_en & ~bai_reg) == 4'h0) |=> !break_req && !complex_match)
    else $error("access on ignored lanes matched");
  a_excl_inside: assert property (@(posedge pclk) disable iff (!presetn)
    (ls_valid && hwart_reg && excl_reg && ls_addr >= addr_reg && ls_addr <= mask_reg)
    |=> !break_req && !complex_match)
    else $error("exclusive range matched inside");
  a_incl_outside: assert property (@(posedge pclk) disable iff (!presetn)
    (ls_valid && hwart_reg && !excl_reg && ls_addr < addr_reg)
    |=> !break_req && !complex_match)
    else $error("inclusive range matched below the bound");
  a_mask_mismatch: assert property (@(posedge pclk) disable iff (!presetn)
    (ls_valid && !hwart_reg && ((ls_addr ^ addr_reg) & ~mask_reg) != `DBC_ZERO32)
    |=> !break_req && !complex_match)
    else $error("unmasked address bit differed but matched");
  a_lane_value: assert property (@(posedge pclk) disable iff (!presetn)
    (ls_valid && !ivm_reg && ((ls_data ^ value_reg) & ~lane_expand(blm_reg)) != `DBC_ZERO32)
    |=> !break_req && !complex_match)
    else $error("compared lane differed but matched");
  a_invert_equal: assert property (@(posedge pclk) disable iff (!presetn)
    (ls_valid && ivm_reg && ((ls_data ^ value_reg) & ~lane_expand(blm_reg)) == `DBC_ZERO32)
    |=> !break_req && !complex_match)
    else $error("inverted compare matched an equal value");
  a_prime_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (ls_valid && prsel_reg != 2'b00 && !primed) |=> !break_req && !complex_match)
    else $error("unprimed channel matched");
  a_counter_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    pass_reg != 16'h0000 |=> !break_req && !trigger_req)
    else $error("action while pass counter nonzero");
  a_complex_needs_cbe: assert property (@(posedge pclk) disable iff (!presetn)
    complex_match |-> $past(cbe_reg))
    else $error("complex match without complex enable");
  a_imprecise_source: assert property (@(posedge pclk) disable iff (!presetn)
    break_imprecise |-> $past(impr_reg) && (break_req || trigger_req))
    else $error("imprecise flag without action or counter write");
  a_value_written: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `DBC_OFF_VALUE) |=> value_reg == $past(pwdata))
    else $error("compare value not written");
  a_range_cap: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == `DBC_OFF_CTRL) |=> prdata[`DBC_C_RANGE_CAP])
    else $error("range capability bit read zero");
  a_paired_reads: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == `DBC_OFF_CPLX) |=> prdata[`DBC_X_TIB_LO +: 4] == PAIRED_INSTR)
    else $error("paired instruction number read wrong");
  a_cplx_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == `DBC_OFF_CPLX) |=> prdata[13:12] == 2'b00 && prdata[8:4] == 5'h00)
    else $error("read-only complex fields not zero");
  a_pass_upper: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == `DBC_OFF_PASS) |=> prdata[31:16] == 16'h0000)
    else $error("pass counter upper half not zero");
  a_status_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `DBC_OFF_STATUS && !pwdata[CHAN_IDX] && !cond) |=> !bs_reg)
    else $error("status bit not cleared by write of zero");

endmodule // dbc_channel

// File: sim/dbc_ls_model.sv
// load/store pipeline model driving single-cycle accesses into the channel
`timescale 1ns/100ps

module dbc_ls_model (
  input  wire logic        pclk,
  output logic             ls_valid,
  output logic             ls_store,
  output logic [31:0]      ls_addr,
  output logic [3:0]       ls_byte_en,
  output logic [31:0]      ls_data
);
  // ************
  // access model
  // ************
  // idle state at time zero
  initial begin
    ls_valid   = 1'b0;
    ls_store   = 1'b0;
    ls_addr    = 32'h0000_0000;
    ls_byte_en = 4'h0;
    ls_data    = 32'h0000_0000;
  end

  // one access cycle; idle lines invert so stale values never look valid
  task automatic issue(input logic st, input logic [31:0] a, input logic [3:0] be,
                       input logic [31:0] d);
    @(posedge pclk);
    ls_valid   <= 1'b1;
    ls_store   <= st;
    ls_addr    <= a;
    ls_byte_en <= be;
    ls_data    <= d;
    @(posedge pclk);
    ls_valid   <= 1'b0;
    ls_store   <= ~st;
    ls_addr    <= ~a;
    ls_byte_en <= ~be;
    ls_data    <= ~d;
  endtask
endmodule // dbc_ls_model

// File: sim/tb_top.sv
// self-checking bench for the data breakpoint channel
`timescale 1ns/100ps
`include "dbc_defines.svh"

module tb_top;
  import dbc_pkg::*;
  // ******************
  // signals and checks
  // ******************
  localparam dbc_word_t V = 32'hA5A5_A5A5;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pair, primed;
  logic break_req, trigger_req, break_imprecise, complex_match, complex_enable;
  logic ls_valid, ls_store, swallow;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, ls_addr, ls_data, q;
  logic [3:0]  ls_byte_en;
  int bad_count, total_checks;

  dbc_channel #(.PAIRED_INSTR(4'h3), .CHAN_IDX(0)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ls_valid(ls_valid), .ls_store(ls_store), .ls_addr(ls_addr), .ls_byte_en(ls_byte_en),
    .ls_data(ls_data), .instr_pair_match(pair), .primed(primed), .break_req(break_req),
    .trigger_req(trigger_req), .break_imprecise(break_imprecise),
    .complex_match(complex_match), .complex_enable(complex_enable));

  dbc_ls_model i_ls (.pclk(pclk), .ls_valid(ls_valid), .ls_store(ls_store),
    .ls_addr(ls_addr), .ls_byte_en(ls_byte_en), .ls_data(ls_data));

  // 25 MHz clock
  always #20 pclk = ~pclk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    if (bad_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // apb transfer: setup, then access held until pready sampled high
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    q = prdata;
    check({31'h0, pready}, 32'h1); // answer came before the limit
    check({31'h0, pslverr}, {31'h0, a == 16'h3000}); // only 16'h3000 among the addresses in use is unmapped
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    check(q, e);
  endtask

  // one access under a control value; hit says whether the condition holds,
  // swallow says the pass counter still eats the break or trigger action
  task automatic acc(input logic [31:0] c, input logic st, input logic [31:0] a,
                     input logic [3:0] be, input logic [31:0] d, input logic hit);
    apb(1'b1, `DBC_OFF_CTRL, c);
    i_ls.issue(st, a, be, d);
    #1;
    check({31'h0, break_req}, {31'h0, hit & c[0] & !swallow});
    check({31'h0, trigger_req}, {31'h0, hit & c[2] & !swallow});
    if (c[2:0] != 3'h0) check({31'h0, complex_match}, {31'h0, hit});
  endtask

  // *********
  // scenarios
  // *********
  // reset values, read-only fields and write masking
  task automatic t_regs;
    rdchk(`DBC_OFF_CTRL, 32'h0000_0400);
    rdchk(`DBC_OFF_CPLX, 32'h0003_0000);
    rdchk(`DBC_OFF_PASS, 32'h0000_0000);
    rdchk(16'h3000, 32'h0000_0000); // unmapped: error response, zero data
    apb(1'b1, `DBC_OFF_VALUE, 32'h5A0F_C3E1);
    rdchk(`DBC_OFF_VALUE, 32'h5A0F_C3E1);
    apb(1'b1, `DBC_OFF_CPLX, 32'hFFFF_FFFF);
    rdchk(`DBC_OFF_CPLX, 32'h0003_8E00);
    apb(1'b1, `DBC_OFF_CTRL, 32'hFFFF_FFFF);
    rdchk(`DBC_OFF_CTRL, 32'h0003_F7F7);
    apb(1'b1, `DBC_OFF_PASS, 32'hFFFF_0000);
    rdchk(`DBC_OFF_PASS, 32'h0000_0000);
  endtask

  // equality-mask match, direction, byte lanes and value compare
  task automatic t_match;
    apb(1'b1, `DBC_OFF_CPLX, 32'h0000_0200);
    // the enable register updates at the access edge; look after it settles
    #1;
    check({31'h0, complex_enable}, 32'h1);
    apb(1'b1, `DBC_OFF_VALUE, V);
    apb(1'b1, `DBC_OFF_ADDR, 32'h0000_1000);
    apb(1'b1, `DBC_OFF_MASK, 32'h0000_000F);
    acc(32'h1, 0, 32'h1004, 4'hF, V, 1);
    rdchk(`DBC_OFF_STATUS, 32'h0000_0001);
    apb(1'b1, `DBC_OFF_STATUS, 32'h0000_0000);
    rdchk(`DBC_OFF_STATUS, 32'h0000_0000);
    acc(32'h1, 0, 32'h1010, 4'hF, V, 0);
    acc(32'h0, 0, 32'h1004, 4'hF, V, 0);
    acc(32'h4, 1, 32'h1004, 4'hF, V, 1);
    acc(32'h2001, 1, 32'h1004, 4'hF, V, 0);
    acc(32'h2001, 0, 32'h1004, 4'hF, V, 1);
    acc(32'h1001, 0, 32'h1004, 4'hF, V, 0);
    acc(32'h1001, 1, 32'h1004, 4'hF, V, 1);
    acc(32'h3C001, 0, 32'h1004, 4'hF, V, 0);
    acc(32'h4001, 0, 32'h1004, 4'h1, V, 0);
    acc(32'h4001, 0, 32'h1004, 4'h3, V, 1);
    acc(32'h1, 0, 32'h1004, 4'hF, 32'hA5A5_A500, 0);
    acc(32'h11, 0, 32'h1004, 4'hF, 32'hA5A5_A500, 1);
    acc(32'h3, 0, 32'h1004, 4'hF, 32'hA5A5_A500, 1);
    acc(32'h3, 0, 32'h1004, 4'hF, V, 0);
  endtask

  // range compare: lower bound in address, upper bound in mask
  task automatic t_range;
    apb(1'b1, `DBC_OFF_MASK, 32'h0000_2000);
    acc(32'h101, 0, 32'h1800, 4'hF, V, 1);
    acc(32'h301, 0, 32'h1800, 4'hF, V, 0);
    acc(32'h301, 0, 32'h3000, 4'hF, V, 1);
    acc(32'h101, 0, 32'h3000, 4'hF, V, 0);
  endtask

  // tuple pairing, bypass and selected priming
  task automatic t_complex;
    apb(1'b1, `DBC_OFF_MASK, 32'h0000_000F);
    apb(1'b1, `DBC_OFF_CPLX, 32'h0000_8200);
    pair <= 1'b0;
    acc(32'h1, 0, 32'h1004, 4'hF, V, 0);
    pair <= 1'b1;
    acc(32'h1, 0, 32'h1004, 4'hF, V, 1);
    apb(1'b1, `DBC_OFF_CPLX, 32'h0000_0200);
    primed <= 1'b0;
    acc(32'h1, 0, 32'h1004, 4'hF, V, 1);
    apb(1'b1, `DBC_OFF_CPLX, 32'h0000_0600);
    acc(32'h1, 0, 32'h1004, 4'hF, V, 0);
    primed <= 1'b1;
    acc(32'h1, 0, 32'h1004, 4'hF, V, 1);
    apb(1'b1, `DBC_OFF_CPLX, 32'h0000_0200);
  endtask

  // pass counter: two matches swallowed, then imprecise breaks; precise capture
  task automatic t_pass;
    apb(1'b1, `DBC_OFF_PASS, 32'h0000_0002);
    swallow = 1'b1;
    acc(32'h1, 0, 32'h1004, 4'hF, V, 1);
    acc(32'h1, 0, 32'h1004, 4'hF, V, 1);
    swallow = 1'b0;
    acc(32'h11, 0, 32'h1004, 4'hF, 32'hA5A5_A500, 1);
    check({31'h0, break_imprecise}, 32'h1);
    rdchk(`DBC_OFF_PASS, 32'h0000_0000);
    rdchk(`DBC_OFF_LOADV, V);
    acc(32'h1, 0, 32'h1004, 4'hF, V, 1);
    check({31'h0, break_imprecise}, 32'h1);
    apb(1'b1, `DBC_OFF_PASS, 32'h0000_0000);
    acc(32'h11, 0, 32'h1004, 4'hF, 32'hA5A5_A500, 1);
    check({31'h0, break_imprecise}, 32'h0);
    rdchk(`DBC_OFF_LOADV, 32'hA5A5_A500);
    acc(32'h1, 0, 32'h1004, 4'hF, 32'h1234_5678, 0);
    rdchk(`DBC_OFF_LOADV, 32'hA5A5_A500);
  endtask

  // reset in mid-run returns the control, complex and pass counter fields to their reset values
  task automatic t_reset_again;
    apb(1'b1, `DBC_OFF_CTRL, 32'hFFFF_FFFF);
    apb(1'b1, `DBC_OFF_CPLX, 32'hFFFF_FFFF);
    apb(1'b1, `DBC_OFF_PASS, 32'h0000_0005);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    check({31'h0, complex_enable}, 32'h0);
    rdchk(`DBC_OFF_CTRL, 32'h0000_0400);
    rdchk(`DBC_OFF_CPLX, 32'h0003_0000);
    rdchk(`DBC_OFF_PASS, 32'h0000_0000);
  endtask

  // ************
  // main program
  // ************
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 16'h0000;
    pwdata = 32'h0000_0000; pair = 1; primed = 1; bad_count = 0; total_checks = 0;
    swallow = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_match;
    t_range;
    t_complex;
    t_pass;
    t_reset_again;
    complete_run;
  end

  // watchdog far beyond the few hundred cycles the program needs
  initial begin
    #(40 * 20000);
    bad_count++;
    complete_run;
  end
endmodule // tb_top
